// ===== design/scb4_decode.sv
// Serial port address decoder steered by the configuration byte
`timescale 1ns/10ps
`include "scb4_map.svh"
module scb4_decode (
  input wire logic clk,
  input wire logic rst,
  scb4_if.dec bus
);
  logic [19:0] io_target;
  logic io_hit;
  logic mem_hit;

  // Port address follows the select bit only with I/O decode enabled
  assign io_target = bus.io_select ? `SCB4_IO_ALT : `SCB4_IO_PRI; // [R4]
  // Not gated by the accelerator enable, so I2C works while it is off
  assign io_hit = bus.io_cycle && !bus.mmio_only &&
                  (bus.io_addr == io_target); // [R5] [R6] [R7]
  // Memory window belongs to the running accelerator
  assign mem_hit = bus.mem_cycle && bus.accel_en &&
                   (bus.mem_offset == `SCB4_MMIO_OFS); // [R6]
  assign bus.sel = io_hit || mem_hit;

  ////////////////////////////////////////////////////////////////////////
  property p_io_pri;
    @(posedge clk) disable iff (rst)
    (bus.io_cycle && !bus.mmio_only && !bus.io_select &&
     bus.io_addr == `SCB4_IO_PRI) |-> bus.sel;
  endproperty
  a_io_pri: assert property (p_io_pri) else $error("no decode at E8"); // [R4]

  property p_io_alt;
    @(posedge clk) disable iff (rst)
    (bus.io_cycle && !bus.mem_cycle && bus.io_select &&
     bus.io_addr == `SCB4_IO_PRI) |-> !bus.sel;
  endproperty
  a_io_alt: assert property (p_io_alt) else $error("E8 hit on alt"); // [R5]

  property p_mmio_only;
    @(posedge clk) disable iff (rst)
    (bus.mmio_only && !bus.mem_cycle) |-> !bus.sel;
  endproperty
  a_mmio_only: assert property (p_mmio_only) else $error("io in mmio"); // [R6]

  property p_io_off;
    @(posedge clk) disable iff (rst)
    (!bus.accel_en && bus.io_cycle && !bus.mmio_only && bus.io_select &&
     bus.io_addr == `SCB4_IO_ALT) |-> bus.sel;
  endproperty
  a_io_off: assert property (p_io_off) else $error("io lost"); // [R7]

  // Mapped-only setting must still answer in the memory window
  property p_mem_only;
    @(posedge clk) disable iff (rst)
    (bus.mmio_only && bus.mem_cycle && bus.accel_en &&
     bus.mem_offset == `SCB4_MMIO_OFS) |-> bus.sel;
  endproperty
  a_mem_only: assert property (p_mem_only) else $error("no FF20"); // [R6]
endmodule

// ===== design/scb4_if.sv
// Carrier between the register top and the serial port decoder
`timescale 1ns/10ps
interface scb4_if;
  logic io_select;
  logic mmio_only;
  logic accel_en;
  logic io_cycle;
  logic mem_cycle;
  logic [19:0] io_addr;
  logic [15:0] mem_offset;
  logic sel;
  modport top (output io_select, output mmio_only, output accel_en,
    output io_cycle, output mem_cycle, output io_addr, output mem_offset,
    input sel);
  modport dec (input io_select, input mmio_only, input accel_en,
    input io_cycle, input mem_cycle, input io_addr, input mem_offset,
    output sel);
endinterface

// ===== design/scb4_map.svh
// Constants for the fourth strap configuration byte and its port decode
// How it works
// [R1] At reset the five upper strap pins load into bits 4 to 0.
// [R2] Register reads and writes work only after the unlock key is written.
// [R3] Any strap pin not pulled low makes the register come up at 1FH.
// [R4] Select bit 0 decodes the serial port at 000E8H, 1 at 000E2H.
// [R5] The select bit matters only while the memory-mapped-only bit is 0.
// [R6] Mapped-only 0 answers at I/O port and FF20H; 1 only at FF20H. The code answers at FF20H only while the accelerator is enabled.
// [R7] I/O decode of the serial port works while the accelerator is disabled.
// [R8] Delay code 00 gives three units, 01 two, 10 one, 11 none.
// [R9] Edge mode 0 delays both strobe edges; mode 1 delays only trailing.
// [R10] Software writes zero to reserved bits and ignores their read value.
// [R11] Unlocked writes to bits 4 to 1 override straps until next reset.
`ifndef SCB4_MAP_SVH
`define SCB4_MAP_SVH
`define SCB4_IDX_CFG 8'h6f
`define SCB4_IDX_KEY 8'h39
`define SCB4_KEY_VAL 8'ha5
`define SCB4_STRAP_ALL 5'h1f
`define SCB4_CFG_RST 8'h00
`define SCB4_KEY_RST 8'h00
`define SCB4_WR_MASK 8'h1e
`define SCB4_BIT_SERIAL_PORT_IO_SELECT 1
`define SCB4_BIT_MMIO 2
`define SCB4_WE_LSB 3
`define SCB4_WE_MSB 4
`define SCB4_IO_PRI 20'h000e8
`define SCB4_IO_ALT 20'h000e2
`define SCB4_MMIO_OFS 16'hff20
`define SCB4_WE_MAX 3
`endif

// ===== design/scb4_pkg.sv
// Types for the fourth strap configuration byte
package scb4_pkg;
  typedef enum logic [1:0] {ST_SYNC_A, ST_SYNC_B, ST_LOAD, ST_RUN}
    scb4_phase_type;
  typedef struct packed {
    scb4_phase_type phase;
    logic [7:0] key;
    logic [7:0] cfg;
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [2:0] we_pipe;
    logic [7:0] rdata;
    logic we_out;
  } scb4_state_type;
endpackage

// ===== design/scb4_top.sv
// Fourth strap configuration byte, unlock key and write strobe delay
`timescale 1ns/10ps
`include "scb4_map.svh"
module scb4_top (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic [4:0] STRAP_PINS_UPPER,
  input wire logic [7:0] REG_INDEX,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic CFG_READY,
  input wire logic WRITE_EDGE_MODE_BIT,
  input wire logic WE_IN_N,
  output logic WE_OUT_N,
  input wire logic ACCEL_ENABLE,
  input wire logic IO_CYCLE,
  input wire logic [19:0] IO_ADDR,
  input wire logic MEM_CYCLE,
  input wire logic [15:0] MEM_OFFSET,
  output logic SERIAL_PORT_SEL
);
  scb4_pkg::scb4_state_type state_reg;
  scb4_pkg::scb4_state_type state_next;
  logic unlocked;
  logic we_in;
  logic we_delayed;
  logic [1:0] we_code;

  scb4_if dec_bus ();

  // Pick the strobe tap; a smaller code means a longer delay
  function automatic logic delay_tap(input logic [1:0] code,
                                     input logic now,
                                     input logic [2:0] pipe);
    logic tap;
    tap = now;
    case (code)
      2'h0: tap = pipe[2];
      2'h1: tap = pipe[1];
      2'h2: tap = pipe[0];
      default: tap = now;
    endcase
    return tap;
  endfunction

  assign unlocked = (state_reg.key == `SCB4_KEY_VAL); // [R2]
  assign we_in = !WE_IN_N;
  assign we_code = state_reg.cfg[`SCB4_WE_MSB:`SCB4_WE_LSB];
  assign we_delayed = delay_tap(we_code, we_in, state_reg.we_pipe); // [R8]

  ////////////////////////////////////////////////////////////////////////
  // Next state: strap capture, register access, strobe shaping
  always_comb begin
    state_next = state_reg;
    // Pins come from outside, so two flops before anyone looks
    state_next.sync_a = STRAP_PINS_UPPER;
    state_next.sync_b = state_reg.sync_a;
    case (state_reg.phase)
      scb4_pkg::ST_SYNC_A: begin
        state_next.phase = scb4_pkg::ST_SYNC_B;
      end
      scb4_pkg::ST_SYNC_B: begin
        state_next.phase = scb4_pkg::ST_LOAD;
      end
      scb4_pkg::ST_LOAD: begin
        // Any strap left high forces the all-ones pattern
        if (|state_reg.sync_b) begin
          state_next.cfg = {3'h0, `SCB4_STRAP_ALL}; // [R3]
        end else begin
          state_next.cfg = {3'h0, state_reg.sync_b}; // [R1]
        end
        state_next.phase = scb4_pkg::ST_RUN;
      end
      default: begin
        // Writes before capture ends would be overwritten, so wait
        if (REG_WR) begin
          if (REG_INDEX == `SCB4_IDX_KEY) begin
            state_next.key = REG_WDATA;
          end else if (REG_INDEX == `SCB4_IDX_CFG && unlocked) begin
            // Bit 0 and reserved bits keep what the straps gave
            state_next.cfg = (state_reg.cfg & ~`SCB4_WR_MASK) |
                             (REG_WDATA & `SCB4_WR_MASK); // [R2] [R11] [R10]
          end
        end
      end
    endcase
    // Read data is held until the next read
    if (REG_RD) begin
      if (REG_INDEX == `SCB4_IDX_KEY) begin
        state_next.rdata = state_reg.key;
      end else if (REG_INDEX == `SCB4_IDX_CFG && unlocked) begin
        state_next.rdata = state_reg.cfg; // [R2]
      end else begin
        state_next.rdata = 8'h00;
      end
    end
    state_next.we_pipe = {state_reg.we_pipe[1:0], we_in};
    // Mode 1 asserts at once and only stretches the release
    if (WRITE_EDGE_MODE_BIT) begin
      state_next.we_out = we_in || we_delayed; // [R9]
    end else begin
      state_next.we_out = we_delayed; // [R9]
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg.phase <= scb4_pkg::ST_SYNC_A;
      state_reg.key <= `SCB4_KEY_RST;
      state_reg.cfg <= `SCB4_CFG_RST;
      state_reg.sync_a <= 5'h00;
      state_reg.sync_b <= 5'h00;
      state_reg.we_pipe <= 3'h0;
      state_reg.rdata <= 8'h00;
      state_reg.we_out <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoder hookup
  assign dec_bus.io_select = state_reg.cfg[`SCB4_BIT_SERIAL_PORT_IO_SELECT];
  assign dec_bus.mmio_only = state_reg.cfg[`SCB4_BIT_MMIO];
  assign dec_bus.accel_en = ACCEL_ENABLE;
  assign dec_bus.io_cycle = IO_CYCLE;
  assign dec_bus.mem_cycle = MEM_CYCLE;
  assign dec_bus.io_addr = IO_ADDR;
  assign dec_bus.mem_offset = MEM_OFFSET;

  scb4_decode u_decode (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .bus(dec_bus)
  );

  // Outputs
  assign SERIAL_PORT_SEL = dec_bus.sel;
  assign REG_RDATA = state_reg.rdata;
  assign CFG_READY = (state_reg.phase == scb4_pkg::ST_RUN);
  assign WE_OUT_N = !state_reg.we_out;

  ////////////////////////////////////////////////////////////////////////
  // Checks; all but a_ce_freeze presume CE stays high across the cycles they span
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST || !CE);

  property p_locked_wr;
    (!unlocked && CFG_READY && REG_WR && REG_INDEX == `SCB4_IDX_CFG)
    |=> $stable(state_reg.cfg);
  endproperty
  a_locked_wr: assert property (p_locked_wr) // [R2]
    else $error("locked write");

  property p_locked_rd;
    (!unlocked && REG_RD && REG_INDEX == `SCB4_IDX_CFG)
    |=> REG_RDATA == 8'h00;
  endproperty
  a_locked_rd: assert property (p_locked_rd) // [R2]
    else $error("locked read");

  property p_unlocked_rd;
    (unlocked && REG_RD && REG_INDEX == `SCB4_IDX_CFG)
    |=> REG_RDATA == $past(state_reg.cfg);
  endproperty
  a_unlocked_rd: assert property (p_unlocked_rd) // [R2]
    else $error("unlocked read");

  // Key stays readable whatever its value, so software can check it
  property p_key_rd;
    (REG_RD && REG_INDEX == `SCB4_IDX_KEY)
    |=> REG_RDATA == $past(state_reg.key);
  endproperty
  a_key_rd: assert property (p_key_rd)
    else $error("key read");

  // Low enable must hold every flop, synchronisers included
  property p_ce_freeze;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !CE |=> $stable(state_reg);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("moved while frozen");

  property p_load;
    (state_reg.phase == scb4_pkg::ST_LOAD && state_reg.sync_b == 5'h00)
    |=> state_reg.cfg == 8'h00 && CFG_READY;
  endproperty
  a_load: assert property (p_load) // [R1]
    else $error("strap low load");

  property p_all_ones;
    (state_reg.phase == scb4_pkg::ST_LOAD && |state_reg.sync_b)
    |=> state_reg.cfg == {3'h0, `SCB4_STRAP_ALL};
  endproperty
  a_all_ones: assert property (p_all_ones) // [R3]
    else $error("not 1F");

  property p_override;
    (unlocked && CFG_READY && REG_WR && REG_INDEX == `SCB4_IDX_CFG)
    |=> state_reg.cfg[4:1] == $past(REG_WDATA[4:1]) &&
        state_reg.cfg[7:5] == 3'h0 && $stable(state_reg.cfg[0]);
  endproperty
  a_override: assert property (p_override) // [R11]
    else $error("override");

  property p_no_delay;
    (we_code == 2'h3 && !WRITE_EDGE_MODE_BIT)
    |=> state_reg.we_out == $past(we_in);
  endproperty
  a_no_delay: assert property (p_no_delay) // [R8]
    else $error("code 11");

  property p_three_units;
    (we_code == 2'h0 && !WRITE_EDGE_MODE_BIT && $rose(we_in))
    ##1 (we_code == 2'h0 && !WRITE_EDGE_MODE_BIT) [*3]
    |=> state_reg.we_out;
  endproperty
  a_three_units: assert property (p_three_units) // [R8]
    else $error("code 00");

  property p_lead_now;
    (WRITE_EDGE_MODE_BIT && we_in) |=> !WE_OUT_N;
  endproperty
  a_lead_now: assert property (p_lead_now) // [R9]
    else $error("lead delayed");
endmodule

// ===== tb/scb4_top_test.sv
// Self-checking bench for the fourth strap configuration byte
`timescale 1ns/10ps
`include "scb4_map.svh"
module scb4_top_test;
logic CLK_SYS = 1'b0;
logic SYS_RST = 1'b1;
logic CE = 1'b1;
logic [4:0] STRAP_PINS_UPPER = 5'h00;
logic [7:0] REG_INDEX = 8'h00;
logic REG_WR = 1'b0;
logic REG_RD = 1'b0;
logic [7:0] REG_WDATA = 8'h00;
logic [7:0] REG_RDATA;
logic CFG_READY;
logic WRITE_EDGE_MODE_BIT = 1'b0;
logic WE_IN_N = 1'b1;
logic WE_OUT_N;
logic ACCEL_ENABLE = 1'b0;
logic IO_CYCLE = 1'b0;
logic [19:0] IO_ADDR = 20'h00000;
logic MEM_CYCLE = 1'b0;
logic [15:0] MEM_OFFSET = 16'h0000;
logic SERIAL_PORT_SEL;
logic rd_seen = 1'b0;
logic [7:0] exp_q[$];
int mismatches = 0;
int tests_run = 0;
int cycles = 0;
int seed = 32'hb428b1a4;
scb4_top dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CE(CE),
  .STRAP_PINS_UPPER(STRAP_PINS_UPPER), .REG_INDEX(REG_INDEX),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .CFG_READY(CFG_READY),
  .WRITE_EDGE_MODE_BIT(WRITE_EDGE_MODE_BIT), .WE_IN_N(WE_IN_N),
  .WE_OUT_N(WE_OUT_N), .ACCEL_ENABLE(ACCEL_ENABLE), .IO_CYCLE(IO_CYCLE),
  .IO_ADDR(IO_ADDR), .MEM_CYCLE(MEM_CYCLE), .MEM_OFFSET(MEM_OFFSET),
  .SERIAL_PORT_SEL(SERIAL_PORT_SEL));
////////////////////////////////////////////////////////////////////////
// 40 MHz clock and a hang limit well above the planned run
initial begin
  forever #12.5 CLK_SYS = ~CLK_SYS;
end
always @(posedge CLK_SYS) begin
  cycles <= cycles + 1;
  rd_seen <= REG_RD;
  if (cycles == 5000) begin
    mismatches++;
    results();
  end
end
// Read data lands one edge after the strobe, so check at the next fall
always @(negedge CLK_SYS) begin
  if (rd_seen && exp_q.size() > 0)
    check(REG_RDATA, exp_q.pop_front());
end
////////////////////////////////////////////////////////////////////////
task automatic check(logic [7:0] seen, logic [7:0] expv);
  tests_run++;
  if (seen !== expv) begin
    mismatches++;
    $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
  end
endtask
task automatic results();
  $display("comparisons %0d mismatches %0d", tests_run, mismatches);
  if (mismatches == 0 && tests_run > 0)
    $display("verification passed");
  else
    $display("verification failed");
  $finish;
endtask
// Register strobes last one cycle, driven on the falling edge
task automatic wr(logic [7:0] idx, logic [7:0] d);
  @(negedge CLK_SYS);
  REG_INDEX = idx;
  REG_WDATA = d;
  REG_WR = 1'b1;
  @(negedge CLK_SYS);
  REG_WR = 1'b0;
endtask
task automatic rd(logic [7:0] idx, logic [7:0] expv);
  @(negedge CLK_SYS);
  REG_INDEX = idx;
  REG_RD = 1'b1;
  exp_q.push_back(expv);
  @(negedge CLK_SYS);
  REG_RD = 1'b0;
endtask
// Straps held steady through capture; bounded wait for the ready flag
task automatic do_reset(logic [4:0] s);
  @(negedge CLK_SYS);
  SYS_RST = 1'b1;
  STRAP_PINS_UPPER = s;
  repeat (5) @(negedge CLK_SYS);
  SYS_RST = 1'b0;
  for (int i = 0; i < 10 && CFG_READY !== 1'b1; i++) @(negedge CLK_SYS);
  check({7'h00, CFG_READY}, 8'h01);
endtask
// Edges from the input change until the shaped strobe follows
task automatic edge_count(logic lvl, int expn);
  int n;
  for (n = 1; n < 8; n++) begin
    @(posedge CLK_SYS);
    #1;
    if (WE_OUT_N === lvl) break;
  end
  check(n[7:0], expn[7:0]);
endtask
////////////////////////////////////////////////////////////////////////
// Main sequence
initial begin
  logic [7:0] d;
  logic [31:0] r;
  logic [4:0] s;
  logic e;
  do_reset(5'h00);
  rd(`SCB4_IDX_CFG, 8'h00);
  wr(`SCB4_IDX_KEY, 8'ha4);
  wr(`SCB4_IDX_CFG, 8'h1e);
  rd(`SCB4_IDX_KEY, 8'ha4);
  wr(`SCB4_IDX_KEY, `SCB4_KEY_VAL);
  rd(`SCB4_IDX_CFG, 8'h00);
  $display("test lock and zero straps done");
  r = $random(seed);
  s = r[4:0];
  if (s == 5'h00) s = 5'h04;
  do_reset(s);
  wr(`SCB4_IDX_KEY, `SCB4_KEY_VAL);
  rd(`SCB4_IDX_CFG, 8'h1f);
  for (int i = 0; i < 4; i++) begin
    r = $random(seed);
    d = r[7:0];
    wr(`SCB4_IDX_CFG, d & `SCB4_WR_MASK);
    rd(`SCB4_IDX_CFG, (d & 8'h1e) | 8'h01);
  end
  // Frozen clock enable must swallow a write to the unlocked byte
  CE = 1'b0;
  wr(`SCB4_IDX_CFG, ~d & `SCB4_WR_MASK);
  CE = 1'b1;
  rd(`SCB4_IDX_CFG, (d & 8'h1e) | 8'h01);
  $display("test strap override done");
  for (int c = 0; c < 4; c++) begin
    wr(`SCB4_IDX_CFG, {5'h00, c[1:0], 1'b0});
    for (int i = 0; i < 16; i++) begin
      @(negedge CLK_SYS);
      r = $random(seed);
      IO_ADDR = r[0] ? (r[1] ? `SCB4_IO_ALT : `SCB4_IO_PRI) : r[27:8];
      MEM_OFFSET = r[2] ? `SCB4_MMIO_OFS : r[23:8];
      IO_CYCLE = r[3];
      MEM_CYCLE = r[4];
      ACCEL_ENABLE = r[5];
      e = (IO_CYCLE && !c[1] &&
        IO_ADDR == (c[0] ? `SCB4_IO_ALT : `SCB4_IO_PRI)) ||
        (MEM_CYCLE && ACCEL_ENABLE && MEM_OFFSET == `SCB4_MMIO_OFS);
      #1;
      check({7'h00, SERIAL_PORT_SEL}, {7'h00, e});
    end
  end
  $display("test serial decode done");
  for (int c = 0; c < 4; c++) begin
    for (int m = 0; m < 2; m++) begin
      wr(`SCB4_IDX_CFG, {3'h0, c[1:0], 3'h0});
      WRITE_EDGE_MODE_BIT = m[0];
      repeat (6) @(negedge CLK_SYS);
      WE_IN_N = 1'b0;
      edge_count(1'b0, m ? 1 : 4 - c);
      repeat (8) @(negedge CLK_SYS);
      WE_IN_N = 1'b1;
      edge_count(1'b1, 4 - c);
    end
  end
  $display("test strobe delay done");
  do_reset(5'h00);
  wr(`SCB4_IDX_KEY, `SCB4_KEY_VAL);
  rd(`SCB4_IDX_CFG, 8'h00);
  repeat (3) @(negedge CLK_SYS);
  check(8'(exp_q.size()), 8'h00);
  $display("test reset recapture done");
  results();
end
endmodule
